/* rtl/relay_port_pkg.sv */
// Constants and types shared by the isolated input and relay output port
package relay_port_pkg;

    localparam int unsigned ADDR_W   = 3;
    localparam int unsigned DATA_W   = 8;

    // Byte offsets within the I/O window
    localparam logic [ADDR_W-1:0] OFS_SENSOR_INPUT_LEVELS     = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_UNASSIGNED_PORT_ONE     = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_RELAY_DRIVE             = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_UNASSIGNED_PORT_THREE   = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_UNASSIGNED_OFFSET_FOUR  = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CONTROL       = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_UNASSIGNED_OFFSET_SIX   = 3'h6;
    localparam logic [ADDR_W-1:0] OFS_UNASSIGNED_OFFSET_SEVEN = 3'h7;

    // Interrupt control field positions
    localparam int unsigned IRQ_ENABLE_BIT  = 7;
    localparam int unsigned IRQ_PENDING_BIT = 6;
    localparam int unsigned TRIG_MODE_BIT0  = 0;
    localparam int unsigned TRIG_MODE_BIT1  = 1;

    // Input channel that feeds interrupt detection
    localparam int unsigned TRIG_CHANNEL    = 0;

    // Reset values and the all-zero read value
    localparam logic [DATA_W-1:0] RELAY_DRIVE_RST   = 8'h00;
    localparam logic [DATA_W-1:0] READ_DATA_RST     = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO         = 8'h00;
    localparam logic              IRQ_ENABLE_RST    = 1'b0;
    localparam logic              IRQ_PENDING_RST   = 1'b0;
    localparam logic              TRIG_PREV_RST     = 1'b1;

    typedef enum logic [1:0] {
        TRIG_LOW_LEVEL    = 2'h0,
        TRIG_HIGH_LEVEL   = 2'h1,
        TRIG_FALLING_EDGE = 2'h2,
        TRIG_RISING_EDGE  = 2'h3
    } trigger_mode_e;

    localparam trigger_mode_e TRIG_MODE_RST = TRIG_LOW_LEVEL;

endpackage : relay_port_pkg

/* rtl/trigger_if.sv */
// Carrier between the register block and the trigger detector
`timescale 1ns/1ps
`default_nettype none

interface trigger_if;
    import relay_port_pkg::*;

    logic          level_in;
    trigger_mode_e mode;
    logic          enable;
    logic          hit;

    modport detector (
        input  level_in,
        input  mode,
        input  enable,
        output hit
    );

    modport control (
        output level_in,
        output mode,
        output enable,
        input  hit
    );
endinterface : trigger_if

`default_nettype wire

/* rtl/trigger_detect.sv */
// Interrupt trigger detector on one input channel
`timescale 1ns/1ps
`default_nettype none

module trigger_detect
    import relay_port_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  rst,
    trigger_if.detector trig
);

    // ==========================================================
    // Previous level for edge detection
    logic prev_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_q <= TRIG_PREV_RST;
        end else begin
            prev_q <= trig.level_in;
        end
    end

    // ==========================================================
    // Condition per selected mode
    logic cond;

    always_comb begin
        cond = 1'b0;
        unique case (trig.mode)
            TRIG_LOW_LEVEL:    cond = ~trig.level_in;              // R9
            TRIG_HIGH_LEVEL:   cond = trig.level_in;               // R9
            TRIG_FALLING_EDGE: cond = prev_q & ~trig.level_in;     // R9
            TRIG_RISING_EDGE:  cond = ~prev_q & trig.level_in;     // R9
        endcase
    end

    // Armed only while interrupts are enabled
    assign trig.hit = trig.enable & cond; // R11

endmodule : trigger_detect

`default_nettype wire

/* rtl/relay_port.sv */
// Isolated sensor input port, relay output port and interrupt control
// Contract
// R1 - A read of offset 0 returns the eight sensor input levels, one bit per channel.
// R2 - An input bit reads one with no voltage on its sensor and zero with voltage applied.
// R3 - Offset 2 is a readable and writable relay drive register, bit n for relay n.
// R4 - Writing one to a relay bit closes that relay and writing zero releases it.
// R5 - Reading the relay register returns the inverse of the value driving the relays.
// R6 - Only the relay port among the data ports accepts writes; other data writes do nothing.
// R7 - Offsets 1, 3, 4, 6 and 7 read as all zeros.
// R8 - Offset 5 holds enable in bit 7, pending in bit 6, mode in bits 1:0, zeros in bits 5:2.
// R9 - Mode 00 is low level, 01 high level, 10 falling edge, 11 rising edge.
// R10 - The interrupt condition is taken from input bit 0.
// R11 - Enable off disables interrupts, enable on enables them, and reset clears it.
// R12 - Pending reads one while an interrupt waits, a read clears it, writes leave it alone.
// R13 - In level modes pending cannot clear until input bit 0 leaves the triggering level. Here this holds only while enable is set, as hit is gated by enable.
// R14 - Software disables interrupts before changing the trigger mode.
// R15 - The input port is eight independent sensor channels wide.
// R16 - The interrupt request is high exactly while pending and enable are both set.
`timescale 1ns/1ps
`default_nettype none

module relay_port
    import relay_port_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [DATA_W-1:0] sensor_level_bits,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_rd,
    input  wire logic              io_wr,
    input  wire logic [DATA_W-1:0] io_wdata,
    output logic      [DATA_W-1:0] io_rdata,
    output logic                   io_rvalid,
    output logic      [DATA_W-1:0] relay_control_bits,
    output logic                   irq_req
);

    // ==========================================================
    // Register state
    logic [DATA_W-1:0] relay_q;
    logic              irq_enable_flag_q;
    logic              irq_pending_flag_q;
    trigger_mode_e     trig_mode_q;
    logic [DATA_W-1:0] rdata_q;
    logic              rvalid_q;
    logic              irq_q;
    logic [DATA_W-1:0] read_mux;
    logic              pending_d;
    logic              pend_clr;
    logic              ctrl_wr;
    logic              enable_d;

    trigger_if trig ();

    assign trig.level_in = sensor_level_bits[TRIG_CHANNEL]; // R10
    assign trig.mode     = trig_mode_q;
    assign trig.enable   = irq_enable_flag_q;

    trigger_detect u_detect (
        .clk_sys (clk_sys),
        .rst     (rst),
        .trig    (trig)
    );

    // ==========================================================
    // Relay drive register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            relay_q <= RELAY_DRIVE_RST;
        end else if (io_wr && io_addr == OFS_RELAY_DRIVE) begin // R3 R6
            relay_q <= io_wdata; // R4
        end
    end

    // ==========================================================
    // Interrupt control: enable and mode
    assign ctrl_wr  = io_wr && io_addr == OFS_INTERRUPT_CONTROL;
    // Enable as it stands after this edge, so the request drops with it
    assign enable_d = ctrl_wr ? io_wdata[IRQ_ENABLE_BIT] : irq_enable_flag_q; // R16

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_enable_flag_q <= IRQ_ENABLE_RST; // R11
            trig_mode_q       <= TRIG_MODE_RST;
        end else if (ctrl_wr) begin
            irq_enable_flag_q <= io_wdata[IRQ_ENABLE_BIT]; // R8
            trig_mode_q       <= trigger_mode_e'({io_wdata[TRIG_MODE_BIT1],
                                                  io_wdata[TRIG_MODE_BIT0]}); // R8 R9
        end
    end

    // ==========================================================
    // Pending flag: set wins over read clear
    assign pend_clr  = io_rd && io_addr == OFS_INTERRUPT_CONTROL; // R12
    // Level modes keep hitting while at level and enabled, so clear cannot take
    assign pending_d = trig.hit | (irq_pending_flag_q & ~pend_clr); // R13

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_pending_flag_q <= IRQ_PENDING_RST;
        end else begin
            irq_pending_flag_q <= pending_d; // R12
        end
    end

    // ==========================================================
    // Interrupt request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= pending_d & enable_d; // R16
        end
    end

    // ==========================================================
    // Read data
    always_comb begin
        read_mux = READ_ZERO; // R7
        unique case (io_addr)
            OFS_SENSOR_INPUT_LEVELS: read_mux = sensor_level_bits; // R1 R2 R15
            OFS_RELAY_DRIVE:         read_mux = ~relay_q;          // R5
            OFS_INTERRUPT_CONTROL: begin
                read_mux[IRQ_ENABLE_BIT]  = irq_enable_flag_q; // R8
                read_mux[IRQ_PENDING_BIT] = irq_pending_flag_q; // R12
                read_mux[TRIG_MODE_BIT1]  = trig_mode_q[1];
                read_mux[TRIG_MODE_BIT0]  = trig_mode_q[0];
            end
            OFS_UNASSIGNED_PORT_ONE,
            OFS_UNASSIGNED_PORT_THREE,
            OFS_UNASSIGNED_OFFSET_FOUR,
            OFS_UNASSIGNED_OFFSET_SIX,
            OFS_UNASSIGNED_OFFSET_SEVEN: read_mux = READ_ZERO; // R7
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q  <= READ_DATA_RST;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= io_rd;
            if (io_rd) begin
                rdata_q <= read_mux;
            end
        end
    end

    assign io_rdata           = rdata_q;
    assign io_rvalid          = rvalid_q;
    assign relay_control_bits = relay_q;
    assign irq_req            = irq_q;

endmodule : relay_port

`default_nettype wire

/* verification/relay_port_sva.sv */
// Assertion checker for the relay port
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module relay_port_sva
    import relay_port_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic [DATA_W-1:0] sensor_level_bits,
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic              io_rd,
    input wire logic              io_wr,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic [DATA_W-1:0] io_rdata,
    input wire logic              io_rvalid,
    input wire logic [DATA_W-1:0] relay_control_bits,
    input wire logic              irq_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_read_answered: assert property (io_rd |=> io_rvalid)
        else $error("read unanswered");
    a_no_stray_valid: assert property (!io_rd |=> !io_rvalid)
        else $error("stray read valid");
    a_sensor_read: assert property (io_rd && io_addr == 3'h0 |=>
        io_rdata == $past(sensor_level_bits)) else $error("sensor read wrong");
    a_relay_write: assert property (io_wr && io_addr == 3'h2 |=>
        relay_control_bits == $past(io_wdata)) else $error("relay write lost");
    a_relay_read: assert property (io_rd && io_addr == 3'h2 |=>
        io_rdata == ~$past(relay_control_bits)) else $error("relay read wrong");
    a_relay_hold: assert property (!(io_wr && io_addr == 3'h2) |=>
        $stable(relay_control_bits)) else $error("relay changed");
    a_unused_zero: assert property (io_rd && io_addr inside {3'h1, 3'h3, 3'h4, 3'h6, 3'h7}
        |=> io_rdata == 8'h00) else $error("unused offset not zero");
    a_ctrl_zeros: assert property (io_rd && io_addr == 3'h5 |=> io_rdata[5:2] == 4'h0)
        else $error("control gap bits set");
    a_irq_disabled: assert property (io_wr && io_addr == 3'h5 && !io_wdata[7]
        ##1 !io_wr |=> !irq_req) else $error("irq while disabled");
    a_irq_off_now: assert property (io_wr && io_addr == 3'h5 && !io_wdata[7]
        |=> !irq_req) else $error("irq outlived enable");
    c_irq_raised: cover property ($rose(irq_req));
    c_pending_read: cover property (io_rvalid && io_rdata[7:6] == 2'h3);
    c_relay_written: cover property (io_wr && io_addr == 3'h2);
endmodule : relay_port_sva

bind relay_port relay_port_sva relay_port_sva_inst (.clk_sys(clk_sys), .rst(rst),
    .sensor_level_bits(sensor_level_bits), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .relay_control_bits(relay_control_bits), .irq_req(irq_req));
`default_nettype wire

/* verification/host_model.sv */
// Host model issuing byte reads and writes
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host driver
module host_model
    import relay_port_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic [DATA_W-1:0] io_rdata,
    input  wire logic              io_rvalid,
    output logic      [ADDR_W-1:0] io_addr,
    output logic                   io_rd,
    output logic                   io_wr,
    output logic      [DATA_W-1:0] io_wdata
);
    initial begin
        io_addr = 3'h0;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk_sys);
        io_wr    <= 1'b0;
        // Released lines show the inverse
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
        @(posedge clk_sys);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk_sys);
        io_rd   <= 1'b0;
        io_addr <= ~a;
        @(posedge clk_sys);
        d = io_rdata;
        v = io_rvalid;
    endtask : rd
endmodule : host_model
`default_nettype wire

/* verification/relay_port_tb.sv */
// Self-checking testbench of the relay port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
// ==========
// Bench
module relay_port_tb
    import relay_port_pkg::*;
();
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic [DATA_W-1:0] sensor_level_bits = 8'hff;
    logic [ADDR_W-1:0] io_addr;
    logic              io_rd;
    logic              io_wr;
    logic              io_rvalid;
    logic              irq_req;
    logic              rd_v;
    logic [DATA_W-1:0] io_wdata;
    logic [DATA_W-1:0] io_rdata;
    logic [DATA_W-1:0] relay_control_bits;
    logic [DATA_W-1:0] rd_d;
    int                n_fail = 0;
    int                check_count = 0;
    int                cycles = 0;
    always #5 clk_sys = ~clk_sys;
    relay_port relay_port_inst (.clk_sys(clk_sys), .rst(rst),
        .sensor_level_bits(sensor_level_bits), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .relay_control_bits(relay_control_bits), .irq_req(irq_req));
    host_model host_model_inst (.clk_sys(clk_sys), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata));
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, string nm);
        host_model_inst.rd(a, rd_d, rd_v);
        `CHK("rvalid", 1'b1, rd_v)
        `CHK(nm, e, rd_d)
    endtask : rdchk
    task automatic t_reset();
        `CHK("relay_rst", 8'h00, relay_control_bits)
        `CHK("irq_rst", 1'b0, irq_req)
        rdchk(3'h5, 8'h00, "ctrl_rst");
        $display("test reset done");
    endtask : t_reset
    task automatic t_ports();
        @(posedge clk_sys);
        sensor_level_bits <= 8'h5a;
        rdchk(3'h0, 8'h5a, "sensor");
        host_model_inst.wr(3'h2, 8'ha5);
        #1 `CHK("relay", 8'ha5, relay_control_bits)
        rdchk(3'h2, 8'h5a, "relay_rd");
        for (int i = 0; i < 8; i++) begin
            if (i != 2 && i != 5) begin
                host_model_inst.wr(i[2:0], 8'hff);
                rdchk(i[2:0], (i == 0) ? 8'h5a : 8'h00, "unused");
            end
        end
        `CHK("relay_keep", 8'ha5, relay_control_bits)
        $display("test ports done");
    endtask : t_ports
    task automatic t_modes();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            host_model_inst.wr(3'h5, {6'h00, m});
            @(posedge clk_sys);
            sensor_level_bits <= {7'h7f, ~m[0]};
            host_model_inst.wr(3'h5, 8'hfc | m);
            rdchk(3'h5, 8'h80 | m, "ctrl_en");
            @(posedge clk_sys);
            sensor_level_bits <= {7'h7f, m[0]};
            repeat (2) @(posedge clk_sys);
            #1 `CHK("irq_hit", 1'b1, irq_req)
            rdchk(3'h5, 8'hc0 | m, "pend");
            if (!m[1]) begin
                @(posedge clk_sys);
                sensor_level_bits <= {7'h7f, ~m[0]};
                rdchk(3'h5, 8'hc0 | m, "pend_lvl");
            end
            rdchk(3'h5, 8'h80 | m, "pend_clr");
            @(posedge clk_sys);
            #1 `CHK("irq_clr", 1'b0, irq_req)
        end
        @(posedge clk_sys);
        sensor_level_bits <= 8'hfe;
        host_model_inst.wr(3'h5, 8'h80);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("irq_lvl", 1'b1, irq_req)
        host_model_inst.wr(3'h5, 8'h00);
        #1 `CHK("irq_off", 1'b0, irq_req)
        rdchk(3'h5, 8'h40, "pend_off");
        $display("test modes done");
    endtask : t_modes
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_ports();
        t_modes();
        results();
    end
endmodule : relay_port_tb
`default_nettype wire
